// *** shared/psram_bus_map.svh ***
`ifndef PSRAM_BUS_MAP_SVH
`define PSRAM_BUS_MAP_SVH
`define WORD_ADDR_BITS 22
`define DATA_BITS 16
`define LOW_ADDR_BITS 16
`define UPPER_ADDR_BITS 6
`define REG_SEL_BIT 3
`define BUS_MODE_BIT 15
`define BUS_NORSYNC_BIT 14
`define RFR_DPD_BIT 4
`define BUS_SETUP_RESET 16'h9D1F
`define RFR_SETUP_RESET 16'h0010
`define ID_VALUE 16'h0A5A
`define PARTIAL_ARRAY_REFRESH_FULL 3'h0
`define PARTIAL_ARRAY_REFRESH_HALF 3'h1
`define PARTIAL_ARRAY_REFRESH_QUARTER 3'h2
`define PARTIAL_ARRAY_REFRESH_EIGHTH 3'h3
`define PARTIAL_ARRAY_REFRESH_NONE 3'h4
`define PARTIAL_ARRAY_REFRESH_TOP_BIT 2
`define REFRESH_ROWS 256
`define REFRESH_PERIOD_NS 15600
`define CLOCK_NS 20
`define REFRESH_CYCLES ((`REFRESH_PERIOD_NS) / (`CLOCK_NS))
`define WAKE_TIME_NS 150000
`define WAKE_CYCLES ((`WAKE_TIME_NS) / (`CLOCK_NS))
`endif

// *** shared/psram_bus_pkg.sv ***
package psram_bus_pkg;
    typedef enum logic [1:0] {
        MODE_ASYNC,
        MODE_NOR_SYNC,
        MODE_FULL_SYNC
    } bus_mode_e;
    typedef enum logic [1:0] {
        PWR_ACTIVE,
        PWR_STANDBY,
        PWR_DEEP_DOWN,
        PWR_WAKING
    } power_state_e;
endpackage : psram_bus_pkg

// *** verilog/psram_self_refresh.sv ***
`timescale 1ns/1ps
`include "psram_bus_map.svh"
module psram_self_refresh
    import psram_bus_pkg::*;
#(
    parameter int ROWS = `REFRESH_ROWS,
    parameter int BASE_CYCLES = `REFRESH_CYCLES
) (
    // Clock and reset.
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // Control.
    input wire logic i_enable,
    input wire logic [2:0] i_partial,
    input wire logic i_hot,
    // Status.
    output logic o_refresh_pulse,
    output logic [7:0] o_row
);
    typedef struct packed {
        logic [31:0] timer;
        logic [7:0] row;
        logic pulse;
    } rf_s;
    rf_s s_reg;
    rf_s s_next;

    // Rows outside the kept part of the array get no refresh pulse but still take a full timer period.
    function automatic logic row_kept(input logic [7:0] r,
                                      input logic [2:0] p);
        logic [2:0] sel;
        logic top;
        sel = {1'b0, p[1:0]};
        top = p[`PARTIAL_ARRAY_REFRESH_TOP_BIT];
        if (p == `PARTIAL_ARRAY_REFRESH_NONE) row_kept = 1'b0;
        else if (sel == `PARTIAL_ARRAY_REFRESH_FULL) row_kept = 1'b1;
        else if (sel == `PARTIAL_ARRAY_REFRESH_HALF) row_kept = (r[7] == top);
        else if (sel == `PARTIAL_ARRAY_REFRESH_QUARTER) row_kept = (r[7:6] == {2{top}});
        else row_kept = (r[7:5] == {3{top}});
    endfunction : row_kept

    always_comb begin
        logic [31:0] limit;
        limit = i_hot ? 32'(BASE_CYCLES / 2) : 32'(BASE_CYCLES);
        s_next = s_reg;
        s_next.pulse = 1'b0;
        if (!i_enable) begin
            s_next.timer = 32'h0;
        end else if (s_reg.timer >= limit - 32'h1) begin
            s_next.timer = 32'h0;
            s_next.row = s_reg.row + 8'h01;
            s_next.pulse = row_kept(s_reg.row, i_partial);
        end else begin
            s_next.timer = s_reg.timer + 32'h1;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) s_reg <= '0;
        else s_reg <= s_next;
    end

    assign o_refresh_pulse = s_reg.pulse;
    assign o_row = s_reg.row;
endmodule : psram_self_refresh

// *** verilog/psram_muxed_bus_interface.sv ***
`timescale 1ns/1ps
`include "psram_bus_map.svh"
module psram_muxed_bus_interface
    import psram_bus_pkg::*;
#(
    parameter int DEPTH = 4194304,
    parameter int WAKE_CYCLES = `WAKE_CYCLES,
    parameter logic [15:0] ID_CODE = `ID_VALUE // Arbitrary value.
) (
    // Clock and reset.
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // Bus control pins, all active low except register select, bus clock and hot.
    input wire logic I_CHIP_ENABLE_N,
    input wire logic I_OUTPUT_ENABLE_N,
    input wire logic I_WRITE_ENABLE_N,
    input wire logic I_HIGH_BYTE_LANE_ENABLE_N,
    input wire logic I_LOW_BYTE_LANE_ENABLE_N,
    input wire logic I_LATCH_ENABLE_N,
    input wire logic I_CONFIG_REGISTER_SELECT,
    input wire logic I_BUS_CLOCK,
    input wire logic I_HOT,
    // Address pins.
    input wire logic [`UPPER_ADDR_BITS-1:0] I_UPPER_ADDRESS_INPUTS,
    // Shared address and data lines.
    input wire logic [`DATA_BITS-1:0] I_SHARED_ADDR_DATA_LINES,
    output logic [`DATA_BITS-1:0] O_SHARED_ADDR_DATA_LINES,
    output logic [`DATA_BITS-1:0] O_SHARED_ADDR_DATA_OE,
    // Status.
    output logic [1:0] O_POWER_STATE,
    output logic O_REFRESH_PULSE
);
    typedef struct packed {
        logic [4:0] ce_s;
        logic [4:0] oe_s;
        logic [4:0] we_s;
        logic [4:0] hb_s;
        logic [4:0] lb_s;
        logic [4:0] le_s;
        logic [4:0] cr_s;
        logic [4:0] clk_s;
        logic [4:0] hot_s;
        logic [21:0] up_s;
        logic [15:0] ad_s1;
        logic [15:0] ad_s2;
        logic [21:0] addr;
        logic addr_valid;
        logic reg_access;
        logic written;
        logic [15:0] bus_setup_register;
        logic [15:0] refresh_setup_register;
        logic [15:0] dout;
        logic [15:0] doe;
        logic [31:0] wake;
        power_state_e pwr;
    } st_s;
    st_s s_reg;
    st_s s_next;
    logic [15:0] mem [DEPTH];
    logic mem_we;
    logic [1:0] mem_be;
    logic [15:0] mem_rd;
    logic refresh_pulse;

    // Synchronised views: bit 1 of each shift is the first usable stage.
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic hb_n;
    logic lb_n;
    logic le_n;
    logic cr;
    logic bclk;
    logic bclk_rise;
    logic le_rise;
    logic [15:0] ad;
    bus_mode_e mode;
    logic [1:0] lanes;

    function automatic bus_mode_e decode_mode(input logic [15:0] b);
        if (b[`BUS_MODE_BIT]) decode_mode = MODE_ASYNC;
        else if (b[`BUS_NORSYNC_BIT]) decode_mode = MODE_NOR_SYNC;
        else decode_mode = MODE_FULL_SYNC;
    endfunction : decode_mode

    // The identification register shares the refresh register's select.
    function automatic logic id_sel(input logic [21:0] a);
        id_sel = !a[`REG_SEL_BIT + 16] && (a[17:16] == 2'h1);
    endfunction : id_sel

    assign ce_n = s_reg.ce_s[1];
    assign oe_n = s_reg.oe_s[1];
    assign we_n = s_reg.we_s[1];
    assign hb_n = s_reg.hb_s[1];
    assign lb_n = s_reg.lb_s[1];
    assign le_n = s_reg.le_s[1];
    assign cr = s_reg.cr_s[1];
    assign bclk = s_reg.clk_s[1];
    assign bclk_rise = bclk & ~s_reg.clk_s[2];
    assign le_rise = le_n & ~s_reg.le_s[2];
    assign ad = s_reg.ad_s2;
    assign mode = decode_mode(s_reg.bus_setup_register);
    assign lanes = {~hb_n, ~lb_n};

    always_comb begin
        logic sync_cap;
        logic async_cap;
        logic wr_ok;
        logic [15:0] rdv;
        logic [15:0] wv;
        wr_ok = 1'b0;
        rdv = 16'h0000;
        wv = 16'h0000;
        s_next = s_reg;
        mem_we = 1'b0;
        mem_be = lanes;
        s_next.ce_s = {s_reg.ce_s[3:0], I_CHIP_ENABLE_N};
        s_next.oe_s = {s_reg.oe_s[3:0], I_OUTPUT_ENABLE_N};
        s_next.we_s = {s_reg.we_s[3:0], I_WRITE_ENABLE_N};
        s_next.hb_s = {s_reg.hb_s[3:0], I_HIGH_BYTE_LANE_ENABLE_N};
        s_next.lb_s = {s_reg.lb_s[3:0], I_LOW_BYTE_LANE_ENABLE_N};
        s_next.le_s = {s_reg.le_s[3:0], I_LATCH_ENABLE_N};
        s_next.cr_s = {s_reg.cr_s[3:0], I_CONFIG_REGISTER_SELECT};
        s_next.clk_s = {s_reg.clk_s[3:0], I_BUS_CLOCK};
        s_next.hot_s = {s_reg.hot_s[3:0], I_HOT};
        s_next.up_s = {s_reg.up_s[15:0], I_UPPER_ADDRESS_INPUTS};
        s_next.ad_s1 = I_SHARED_ADDR_DATA_LINES;
        s_next.ad_s2 = s_reg.ad_s1;
        sync_cap = (mode != MODE_ASYNC) && bclk_rise && !le_n;
        async_cap = le_rise;
        // Deep power-down leaves through a wake delay; setup is retained except the refresh register's DPD bit, which is set again.
        unique case (s_reg.pwr)
            PWR_ACTIVE, PWR_STANDBY: begin
                if (ce_n) begin
                    s_next.addr_valid = 1'b0;
                    s_next.written = 1'b0;
                    if (!s_reg.refresh_setup_register[`RFR_DPD_BIT])
                        s_next.pwr = PWR_DEEP_DOWN;
                    else
                        s_next.pwr = PWR_STANDBY;
                end else begin
                    s_next.pwr = PWR_ACTIVE;
                end
            end
            PWR_DEEP_DOWN: begin
                if (!ce_n) begin
                    s_next.pwr = PWR_WAKING;
                    s_next.wake = 32'h0;
                end
            end
            PWR_WAKING: begin
                s_next.wake = s_reg.wake + 32'h1;
                if (s_reg.wake >= 32'(WAKE_CYCLES) - 32'h1) begin
                    s_next.pwr = PWR_STANDBY;
                    s_next.refresh_setup_register[`RFR_DPD_BIT] = 1'b1;
                end
            end
        endcase
        if (s_reg.pwr == PWR_ACTIVE && !ce_n) begin
            if (sync_cap || async_cap) begin
                s_next.addr = {s_reg.up_s[11:6], ad};
                s_next.addr_valid = 1'b1;
                s_next.reg_access = cr;
                s_next.written = 1'b0;
            end
            // Writes are taken once per address phase in the sync modes, every cycle in async mode, on the lanes open.
            wr_ok = (mode != MODE_NOR_SYNC) || le_n;
            if (s_reg.addr_valid && !we_n && !s_reg.written && le_n
                && wr_ok && lanes != 2'b00) begin
                s_next.written = (mode == MODE_ASYNC) ? 1'b0 : 1'b1;
                if (s_reg.reg_access) begin
                    wv = s_reg.addr[`REG_SEL_BIT + 16]
                        ? s_reg.bus_setup_register
                        : s_reg.refresh_setup_register;
                    if (lanes[1]) wv[15:8] = ad[15:8];
                    if (lanes[0]) wv[7:0] = ad[7:0];
                    if (s_reg.addr[`REG_SEL_BIT + 16])
                        s_next.bus_setup_register = wv;
                    else if (!id_sel(s_reg.addr))
                        s_next.refresh_setup_register = wv;
                end else begin
                    mem_we = 1'b1;
                end
            end
        end
        if (!s_reg.reg_access) rdv = mem_rd;
        else if (s_reg.addr[`REG_SEL_BIT + 16])
            rdv = s_reg.bus_setup_register;
        else if (id_sel(s_reg.addr)) rdv = ID_CODE;
        else rdv = s_reg.refresh_setup_register;
        s_next.dout = {lanes[1] ? rdv[15:8] : 8'h00,
                       lanes[0] ? rdv[7:0] : 8'h00};
        s_next.doe = '0;
        if (s_reg.pwr == PWR_ACTIVE && !ce_n && !oe_n && we_n
            && le_n && s_reg.addr_valid) begin
            s_next.doe = {{8{lanes[1]}}, {8{lanes[0]}}};
        end
    end

    // Array port; the identification register has no write path.
    always_ff @(posedge I_CLOCK) begin
        if (mem_we) begin
            if (mem_be[1]) mem[s_reg.addr][15:8] <= s_reg.ad_s2[15:8];
            if (mem_be[0]) mem[s_reg.addr][7:0] <= s_reg.ad_s2[7:0];
        end
        mem_rd <= mem[s_next.addr];
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            s_reg <= '0;
            s_reg.ce_s <= 5'h1F;
            s_reg.oe_s <= 5'h1F;
            s_reg.we_s <= 5'h1F;
            s_reg.hb_s <= 5'h1F;
            s_reg.lb_s <= 5'h1F;
            s_reg.le_s <= 5'h1F;
            s_reg.bus_setup_register <= `BUS_SETUP_RESET;
            s_reg.refresh_setup_register <= `RFR_SETUP_RESET;
            s_reg.pwr <= PWR_STANDBY;
        end else begin
            s_reg <= s_next;
        end
    end

    psram_self_refresh u_refresh (
        .I_CLOCK(I_CLOCK),
        .I_RST_N(I_RST_N),
        .i_enable(s_reg.pwr != PWR_DEEP_DOWN),
        .i_partial(s_reg.refresh_setup_register[2:0]),
        .i_hot(s_reg.hot_s[1]),
        .o_refresh_pulse(refresh_pulse),
        .o_row()
    );

    assign O_SHARED_ADDR_DATA_LINES = s_reg.dout;
    assign O_SHARED_ADDR_DATA_OE = s_reg.doe;
    assign O_POWER_STATE = s_reg.pwr;
    assign O_REFRESH_PULSE = refresh_pulse;
endmodule : psram_muxed_bus_interface

// *** sim/psram_bus_properties.sv ***
`timescale 1ns/1ps
module psram_bus_props
    import psram_bus_pkg::*;
(
    // Clock and reset.
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // Bus pins.
    input wire logic I_CHIP_ENABLE_N,
    input wire logic I_OUTPUT_ENABLE_N,
    input wire logic I_HIGH_BYTE_LANE_ENABLE_N,
    input wire logic I_LOW_BYTE_LANE_ENABLE_N,
    // Outputs.
    input wire logic [15:0] O_SHARED_ADDR_DATA_OE,
    input wire logic [1:0] O_POWER_STATE,
    input wire logic O_REFRESH_PULSE
);
    wire logic [15:0] oe = O_SHARED_ADDR_DATA_OE;
    wire logic [1:0] ps = O_POWER_STATE;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    // Eight cycles cover the pin synchronisers plus the output register.
    property p_ce; I_CHIP_ENABLE_N [*8] |-> oe == 16'h0000; endproperty
    a_ce: assert property (p_ce) else $error("drive while off");
    property p_rd; I_OUTPUT_ENABLE_N [*8] |-> oe == 16'h0000; endproperty
    a_rd: assert property (p_rd) else $error("drive without read");
    property p_no;
        (I_HIGH_BYTE_LANE_ENABLE_N && I_LOW_BYTE_LANE_ENABLE_N) [*8]
            |-> oe == 16'h0000;
    endproperty
    a_no: assert property (p_no) else $error("drive with no lane");
    property p_hb; I_HIGH_BYTE_LANE_ENABLE_N [*8] |-> oe[15:8] == 8'h00;
    endproperty
    a_hb: assert property (p_hb) else $error("high lane driven");
    property p_lb; I_LOW_BYTE_LANE_ENABLE_N [*8] |-> oe[7:0] == 8'h00;
    endproperty
    a_lb: assert property (p_lb) else $error("low lane driven");
    property p_sb;
        I_CHIP_ENABLE_N [*8] |-> ps inside {PWR_STANDBY, PWR_DEEP_DOWN};
    endproperty
    a_sb: assert property (p_sb) else $error("awake while off");
    // Standby is legal for a few cycles right after a wake-up completes.
    property p_act;
        (!I_CHIP_ENABLE_N && ps != PWR_WAKING && ps != PWR_DEEP_DOWN) [*8]
            |-> ps == PWR_ACTIVE;
    endproperty
    a_act: assert property (p_act) else $error("idle while on");
    property p_dpd; (ps == PWR_DEEP_DOWN) [*2] |-> !O_REFRESH_PULSE;
    endproperty
    a_dpd: assert property (p_dpd) else $error("refresh when down");
    property p_pls; O_REFRESH_PULSE |=> !O_REFRESH_PULSE; endproperty
    a_pls: assert property (p_pls) else $error("long refresh pulse");
    c_read: cover property (oe == 16'hFFFF);
    c_down: cover property (ps == PWR_DEEP_DOWN);
    c_rfr: cover property (O_REFRESH_PULSE);
endmodule : psram_bus_props
bind psram_muxed_bus_interface psram_bus_props chk_u (.*);

// *** sim/psram_bus_master.sv ***
`timescale 1ns/1ps
module psram_bus_master (
    // Clock.
    input wire logic i_clock,
    // Control pins.
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic o_hb_n,
    output logic o_lb_n,
    output logic o_le_n,
    output logic o_cr,
    output logic o_kclk,
    // Address and data.
    output logic [5:0] o_up,
    output logic [15:0] o_ad
);
    logic sync_on = 1'b0;
    logic run = 1'b0;
    logic held = 1'b0;
    logic [15:0] drv = 16'h0000;
    logic [15:0] stale = 16'h0000;
    event look;
    // The task owns drv alone, so no two processes race on the lines.
    assign o_ad = held ? drv : stale;
    initial begin
        {o_ce_n, o_oe_n, o_we_n, o_hb_n, o_lb_n, o_le_n} = 6'h3F;
        {o_cr, o_kclk, o_up, drv} = 24'h000000;
        #7;
        forever #80 o_kclk = run ? ~o_kclk : 1'b0;
    end
    // Released lines toggle so a stale value never passes for data.
    always @(negedge i_clock) stale <= ~stale;
    task automatic xfer(input logic rd, input logic c, input logic [21:0] a,
            input logic [15:0] d, input logic [1:0] ln);
        @(negedge i_clock);
        {o_ce_n, o_le_n, o_cr, o_up} = {2'b00, c, a[21:16]};
        {held, drv} = {1'b1, a[15:0]};
        run = sync_on;
        repeat (sync_on ? 24 : 5) @(negedge i_clock);
        o_le_n = 1'b1;
        repeat (4) @(negedge i_clock);
        held = 1'b0;
        @(negedge i_clock);
        {o_hb_n, o_lb_n} = ~ln;
        if (rd) begin
            o_oe_n = 1'b0;
            repeat (8) @(negedge i_clock);
            -> look;
            @(negedge i_clock);
            o_oe_n = 1'b1;
        end else begin
            {held, drv, o_we_n} = {1'b1, d, 1'b0};
            repeat (6) @(negedge i_clock);
            o_we_n = 1'b1;
            @(negedge i_clock);
            held = 1'b0;
        end
        {o_ce_n, o_hb_n, o_lb_n, run} = 4'hE;
        repeat (6) @(negedge i_clock);
    endtask : xfer
endmodule : psram_bus_master

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import psram_bus_pkg::*;
    logic i_clock = 1'b0;
    logic rst_n = 1'b0;
    logic hot = 1'b0;
    logic o_ce_n, o_oe_n, o_we_n, o_hb_n, o_lb_n, o_le_n, o_cr, o_kclk;
    logic [5:0] o_up;
    logic [15:0] o_ad, dout, oe;
    logic [1:0] ps;
    wire logic [15:0] line = (oe & dout) | (~oe & o_ad);
    logic [32:0] notes [$];
    logic [15:0] mem [logic [21:0]];
    int err_total = 0;
    int checked = 0;
    always #10 i_clock = ~i_clock;
    psram_bus_master pm_u (.*);
    psram_muxed_bus_interface #(
        .WAKE_CYCLES(20),
        .ID_CODE(16'h1234) // Arbitrary value.
    ) dut_u (
        .I_CLOCK(i_clock),
        .I_RST_N(rst_n),
        .I_CHIP_ENABLE_N(o_ce_n),
        .I_OUTPUT_ENABLE_N(o_oe_n),
        .I_WRITE_ENABLE_N(o_we_n),
        .I_HIGH_BYTE_LANE_ENABLE_N(o_hb_n),
        .I_LOW_BYTE_LANE_ENABLE_N(o_lb_n),
        .I_LATCH_ENABLE_N(o_le_n),
        .I_CONFIG_REGISTER_SELECT(o_cr),
        .I_BUS_CLOCK(o_kclk),
        .I_HOT(hot),
        .I_UPPER_ADDRESS_INPUTS(o_up),
        .I_SHARED_ADDR_DATA_LINES(line),
        .O_SHARED_ADDR_DATA_LINES(dout),
        .O_SHARED_ADDR_DATA_OE(oe),
        .O_POWER_STATE(ps),
        .O_REFRESH_PULSE()
    );
    task automatic complete_run;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic rd(input logic c, input logic [21:0] a,
            input logic [15:0] d, input logic [1:0] ln);
        notes.push_back({1'b0, {8{ln[1]}}, {8{ln[0]}}, d});
        pm_u.xfer(1'b1, c, a, 16'h0000, ln);
    endtask : rd
    task automatic wr(input logic c, input logic [21:0] a,
            input logic [15:0] d, input logic [1:0] ln);
        if (!c) begin
            mem[a] = {ln[1] ? d[15:8] : mem[a][15:8],
                ln[0] ? d[7:0] : mem[a][7:0]};
        end
        pm_u.xfer(1'b0, c, a, d, ln);
    endtask : wr
    task automatic pchk(input logic [1:0] s);
        notes.push_back({1'b1, 30'h00000000, s});
        @(negedge i_clock);
        -> pm_u.look;
    endtask : pchk
    always @(pm_u.look) begin
        logic [32:0] n;
        n = notes.pop_front();
        checked++;
        if (n[32] ? (ps !== n[1:0]) : (oe !== n[31:16]
                || (dout & oe) !== (n[15:0] & n[31:16]))) begin
            err_total++;
            $display("FAIL %s exp %h seen %h", n[32] ? "power" : "word",
                n[31:0], n[32] ? {30'h0, ps} : {oe, dout & oe});
        end
    end
    always begin
        repeat (50) @(negedge i_clock);
        hot = 1'($urandom);
    end
    initial begin
        #300000;
        err_total++;
        $display("FAIL watchdog exp done seen hang");
        complete_run();
    end
    initial begin
        logic [21:0] a;
        logic [15:0] d;
        void'($urandom(8337));
        repeat (8) @(negedge i_clock);
        rst_n = 1'b1;
        repeat (4) @(negedge i_clock);
        rd(1'b1, 22'h080000, 16'h9D1F, 2'h3);
        rd(1'b1, 22'h000000, 16'h0010, 2'h3);
        wr(1'b1, 22'h015555, 16'h5555, 2'h3);
        rd(1'b1, 22'h010000, 16'h1234, 2'h3);
        rd(1'b1, 22'h000000, 16'h0010, 2'h3);
        pchk(PWR_STANDBY);
        for (int i = 0; i < 6; i++) begin
            a = 22'($urandom);
            d = 16'($urandom);
            wr(1'b0, a, d, 2'h3);
            wr(1'b0, a, ~d, 2'(i % 4));
            rd(1'b0, a, mem[a], 2'(3 - i % 4));
        end
        wr(1'b1, 22'h000000, 16'h0000, 2'h3);
        repeat (10) @(negedge i_clock);
        pchk(PWR_DEEP_DOWN);
        pm_u.o_ce_n = 1'b0;
        repeat (60) @(negedge i_clock);
        pchk(PWR_ACTIVE);
        pm_u.o_ce_n = 1'b1;
        rd(1'b1, 22'h000000, 16'h0010, 2'h3);
        wr(1'b1, 22'h081D1F, 16'h1D1F, 2'h3);
        pm_u.sync_on = 1'b1;
        wr(1'b0, a, d, 2'h3);
        rd(1'b0, a, mem[a], 2'h3);
        wr(1'b1, 22'h085D1F, 16'h5D1F, 2'h3);
        wr(1'b0, a, ~d, 2'h3);
        rd(1'b0, a, mem[a], 2'h3);
        rd(1'b1, 22'h080000, 16'h5D1F, 2'h3);
        complete_run();
    end
endmodule : tb_top
